// >>> bench/iusr_pipe_model.sv
// pipeline-side model driving execution, trap and register file pins
`timescale 1ns/100ps
`default_nettype none
module iusr_pipe_model
(
  input wire logic core_clk,
  output logic [3:0] req,
  output logic [7:0] sw_type,
  output logic [3:0] irq_level,
  output logic icc_wr,
  output logic [3:0] icc_in,
  output logic [4:0] ra_idx,
  output logic [4:0] rb_idx,
  output logic gpr_wr,
  output logic [4:0] wr_idx,
  output logic [31:0] wr_data
);
  initial
  begin
    {req, sw_type, irq_level, icc_wr, icc_in} = '0;
    {ra_idx, rb_idx, gpr_wr, wr_idx, wr_data} = '0;
  end
  // req order is save, restore, return, software trap
  task automatic pulse(input logic [3:0] k, input logic [7:0] t);
    @(posedge core_clk);
    req <= k;
    sw_type <= t;
    @(posedge core_clk);
    req <= 4'h0;
  endtask
  task automatic gwr(input logic [4:0] i, input logic [31:0] d);
    @(posedge core_clk);
    {gpr_wr, wr_idx, wr_data} <= {1'b1, i, d};
    @(posedge core_clk);
    gpr_wr <= 1'b0;
    // data lines do not keep the last value once released
    wr_data <= ~d;
  endtask
  task automatic flags(input logic [3:0] f);
    @(posedge core_clk);
    {icc_wr, icc_in} <= {1'b1, f};
    @(posedge core_clk);
    icc_wr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> bench/iusr_state_regs_asserts.sv
// concurrent checks on the state register block ports
`timescale 1ns/100ps
`default_nettype none
module iusr_state_regs_asserts
  import iusr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic save_req,
  input wire logic restore_req,
  input wire logic rett_req,
  input wire logic sw_trap_req,
  input wire logic [7:0] sw_trap_type,
  input wire logic trap_taken,
  input wire logic [31:0] trap_vector,
  input wire logic [4:0] ra_idx,
  input wire logic [31:0] ra_data,
  input wire logic supervisor,
  input wire logic single_vector
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [3:0] a);
    reg_rd && clk_en && reg_addr == a;
  endsequence
  // a window trap outranks the software request, so it is excluded
  sequence s_sw_req;
    sw_trap_req && clk_en && !save_req && !restore_req && !rett_req && !single_vector;
  endsequence
  a_status_fields: assert property (s_rd(ADDR_STATUS) |=> reg_rdata[31:24] == IMPL_VER_ID
    && reg_rdata[19:12] == 8'h0 && reg_rdata[4:3] == 2'h0 && reg_rdata[7] == $past(supervisor))
    else $error("status read fields wrong");
  a_wim_upper: assert property (s_rd(ADDR_WIM) |=> reg_rdata[31:8] == 24'h0)
    else $error("mask upper bits not zero");
  a_vector_nibble: assert property (trap_vector[3:0] == 4'h0)
    else $error("vector low nibble not zero");
  a_svt_read: assert property (s_rd(ADDR_SVT) |=> reg_rdata == {31'h0, $past(single_vector)})
    else $error("single vector read wrong");
  a_svt_write: assert property (reg_wr && clk_en && reg_addr == ADDR_SVT
    |=> single_vector == $past(reg_wdata[0]))
    else $error("single vector write lost");
  a_zero_reg: assert property (ra_idx == 5'h0 && clk_en |=> ra_data == 32'h0)
    else $error("register zero not zero");
  a_trap_super: assert property (trap_taken |-> supervisor)
    else $error("trap left user mode");
  a_sw_code: assert property (s_sw_req |=> trap_taken && trap_vector[11:4] == $past(sw_trap_type))
    else $error("software trap code wrong");
endmodule
bind iusr_state_regs iusr_state_regs_asserts u_chk (.core_clk(core_clk), .rst(rst),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .save_req(save_req), .restore_req(restore_req),
  .rett_req(rett_req), .sw_trap_req(sw_trap_req), .sw_trap_type(sw_trap_type),
  .trap_taken(trap_taken), .trap_vector(trap_vector), .ra_idx(ra_idx), .ra_data(ra_data),
  .supervisor(supervisor), .single_vector(single_vector));
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the state registers and windowed file
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import iusr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, trap_vector, ra_data, rb_data, wr_data, d;
  logic [3:0] req, irq_level, icc_in;
  logic [7:0] sw_type;
  logic [4:0] ra_idx, rb_idx, wr_idx;
  logic icc_wr, gpr_wr, trap_taken, win_ok, supervisor, single_vector, hit;
  int fails = 0;
  int n_tests = 0;
  always #2 core_clk = ~core_clk;
  iusr_pipe_model p (.core_clk(core_clk), .req(req), .sw_type(sw_type),
    .irq_level(irq_level), .icc_wr(icc_wr), .icc_in(icc_in), .ra_idx(ra_idx),
    .rb_idx(rb_idx), .gpr_wr(gpr_wr), .wr_idx(wr_idx), .wr_data(wr_data));
  iusr_state_regs dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .icc_wr(icc_wr), .icc_in(icc_in), .save_req(req[3]),
    .restore_req(req[2]), .rett_req(req[1]), .sw_trap_req(req[0]), .sw_trap_type(sw_type),
    .irq_level(irq_level), .trap_taken(trap_taken), .trap_vector(trap_vector),
    .win_ok(win_ok), .ra_idx(ra_idx), .rb_idx(rb_idx), .gpr_wr(gpr_wr),
    .gpr_wr_idx(wr_idx), .gpr_wr_data(wr_data), .ra_data(ra_data), .rb_data(rb_data),
    .supervisor(supervisor), .single_vector(single_vector));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // reserved fields are always written as zero
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_trap(input int n);
    hit = 1'b0;
    repeat (n)
    begin
      @(posedge core_clk);
      #1 hit |= (trap_taken === 1'b1);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(ADDR_STATUS);
    check("status reset", d, {IMPL_VER_ID, 24'h000080});
    wr(ADDR_STATUS, 32'h00a003a5);
    rd(ADDR_STATUS);
    check("status", d, 32'h5aa003a5);
    p.flags(4'h5);
    rd(ADDR_STATUS);
    check("flags", d[23:20], 4'h5);
    wr(ADDR_WIM, 32'h02);
    rd(ADDR_WIM);
    check("mask", d, 32'h02);
    wr(ADDR_TBV, 32'habcde000);
    rd(ADDR_TBV);
    check("base", d, 32'habcde000);
    rd(4'h7);
    check("unmapped", d, 32'h0);
    clk_en <= 1'b0;
    wr(ADDR_WIM, 32'hff);
    clk_en <= 1'b1;
    rd(ADDR_WIM);
    check("frozen", d, 32'h02);
  endtask
  task automatic t_gpr();
    p.gwr(5'h18, 32'h11110024);
    p.gwr(5'h01, 32'h00000001);
    p.gwr(5'h00, 32'hffffffff);
    @(posedge core_clk);
    {ra_idx, rb_idx} <= {5'h18, 5'h00};
    @(posedge core_clk);
    #1 check("window in", ra_data, 32'h11110024);
    check("zero reg", rb_data, 32'h0);
    wr(ADDR_STATUS, 32'h000000a6);
    @(posedge core_clk);
    {ra_idx, rb_idx} <= {5'h08, 5'h01};
    @(posedge core_clk);
    #1 check("overlap", ra_data, 32'h11110024);
    check("global", rb_data, 32'h00000001);
  endtask
  task automatic t_traps();
    wr(ADDR_STATUS, 32'h000000a2);
    fork
      p.pulse(4'b1000, 8'h00);
      begin
        @(posedge core_clk);
        #1 check("ovf flag", win_ok, 1'b0);
      end
    join
    #1 check("ovf taken", trap_taken, 1'b1);
    check("ovf vector", trap_vector, 32'habcde050);
    rd(ADDR_STATUS);
    check("trap state", d, 32'h5a0000c1);
    p.pulse(4'b0010, 8'h00);
    rd(ADDR_STATUS);
    check("return", d, 32'h5a0000e2);
    wr(ADDR_WIM, 32'h0);
    wr(ADDR_STATUS, 32'h000003a2);
    p.irq_level <= 4'h2;
    wait_trap(8);
    check("below level", hit, 1'b0);
    p.irq_level <= 4'h4;
    wait_trap(8);
    check("irq taken", {hit, trap_vector[11:4]}, 9'h114);
    wr(ADDR_STATUS, 32'h00000fa2);
    p.irq_level <= 4'hf;
    wait_trap(8);
    check("top level", {hit, trap_vector[11:4]}, 9'h11f);
    p.irq_level <= 4'h0;
    rd(ADDR_STATUS);
    check("irq window", d[2:0], 3'h1);
  endtask
  task automatic t_svt();
    wr(ADDR_STATUS, 32'h000000a2);
    p.pulse(4'b0001, 8'h44);
    #1 check("sw vector", trap_vector, 32'habcde440);
    wr(ADDR_SVT, 32'h1);
    rd(ADDR_SVT);
    check("svt", d, 32'h1);
    wr(ADDR_STATUS, 32'h000000a2);
    p.pulse(4'b0001, 8'h33);
    #1 check("single", trap_vector, 32'habcde000);
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_gpr();
    t_traps();
    t_svt();
    final_report();
  end
  initial
  begin
    #20000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire

// >>> pkg/iusr_pkg.sv
// package for the integer-unit state and windowed register file
package iusr_pkg;
  // ----------------------------------------------------------------
  // register map (index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_WIM = 4'h1;
  localparam logic [3:0] ADDR_TBV = 4'h2;
  localparam logic [3:0] ADDR_SVT = 4'h3;
  // ----------------------------------------------------------------
  // status word layout
  // ----------------------------------------------------------------
  localparam int ICC_HI = 23;
  localparam int ICC_LO = 20;
  localparam int PIL_HI = 11;
  localparam int PIL_LO = 8;
  localparam int SUP_BIT = 7;
  localparam int PRIOR_BIT = 6;
  localparam int ET_BIT = 5;
  localparam int CWP_HI = 2;
  localparam int CWP_LO = 0;
  // implementation and version fields, values arbitrary
  localparam logic [7:0] IMPL_VER_ID = 8'h5a;
  localparam int IMPL_LO = 24;
  localparam int TBA_LO = 12;
  localparam int TT_LO = 4;
  localparam int WIM_W = 8;
  // ----------------------------------------------------------------
  // register file geometry
  // ----------------------------------------------------------------
  localparam int NWIN = 8;
  localparam int NGLOB = 8;
  localparam int NPHYS = 136;
  localparam int WIN_STRIDE = 16;
  localparam logic [4:0] IDX_IN_LO = 5'h18;
  localparam logic [7:0] NMI_LEVEL = 8'h0f;
  localparam logic [7:0] TT_WIN_OVF = 8'h05;
  localparam logic [7:0] TT_WIN_UNF = 8'h06;
  localparam logic [7:0] TT_INTR_BASE = 8'h10;

  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } iusr_reg_req_t;

  typedef struct packed {
    logic [3:0] icc;
    logic [3:0] processor_interrupt_level;
    logic sup;
    logic prior;
    logic et;
    logic [2:0] current_window_pointer;
  } iusr_status_t;
endpackage

// >>> rtl/iusr_gpr_bank.sv
// physical general register storage with window address mapping
`timescale 1ns/100ps
`default_nettype none
module iusr_gpr_bank
(
  input wire logic core_clk,
  input wire logic clk_en,
  input wire logic [2:0] current_window_pointer,
  input wire logic [4:0] ra_idx,
  input wire logic [4:0] rb_idx,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [31:0] wr_data,
  output logic [31:0] ra_data,
  output logic [31:0] rb_data
);
  import iusr_pkg::*;

  // no reset on purpose: contents are undefined after reset
  logic [31:0] mem_r [NPHYS];

  // ----------------------------------------------------------------
  // window mapping
  // ----------------------------------------------------------------
  // globals shared, 24 windowed
  // ins of window w are outs of w+1
  function automatic logic [7:0] phys_idx(input logic [2:0] w, input logic [4:0] r);
    logic [7:0] base;
    logic [7:0] off;
    base = 8'(NGLOB);
    off = 8'h00;
    if (r < 5'(NGLOB))
      phys_idx = {3'h0, r};
    else
    begin
      if (r >= IDX_IN_LO)
        off = 8'(({1'b0, w} + 4'h1) & 4'h7) * 8'(WIN_STRIDE) + 8'(r - IDX_IN_LO);
      else
        off = 8'(w) * 8'(WIN_STRIDE) + 8'(r) - 8'(NGLOB);
      phys_idx = base + off;
    end
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (clk_en && wr_en && wr_idx != 5'h00)
      mem_r[phys_idx(current_window_pointer, wr_idx)] <= wr_data;
  end

  always_ff @(posedge core_clk)
  begin
    if (clk_en)
    begin
      ra_data <= (ra_idx == 5'h00) ? 32'h0000_0000 : mem_r[phys_idx(current_window_pointer, ra_idx)];
      rb_data <= (rb_idx == 5'h00) ? 32'h0000_0000 : mem_r[phys_idx(current_window_pointer, rb_idx)];
    end
  end
endmodule
`default_nettype wire

// >>> rtl/iusr_state_regs.sv
// integer-unit state registers with trap sequencing and register file
`timescale 1ns/100ps
`default_nettype none
// Contract
// - flags n z v c at 23:20
// - reserved bits: write zero, read undefined
// - four-bit interrupt level at 11:8
// - supervisor bit 7 resets one; prior bit 6
// - trap enable bit 5 reset clear
// - window pointer in bits 2:0
// - eight-bit window invalid mask
// - trap base high bits, low nibble zero
// - trap type code bits 11:4
// - single vector enable bit 0, reset clear
// - 136 registers of 32 bits
// - eight windows, 32 visible registers
// - pointer selects visible window
// - eight globals plus 24 windowed
// - adjacent windows overlap ins and outs
// - general registers not reset
// - fifteen levels, top level nonmaskable
// - interrupt moves to new window
module iusr_state_regs
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic icc_wr,
  input wire logic [3:0] icc_in,
  input wire logic save_req,
  input wire logic restore_req,
  input wire logic rett_req,
  input wire logic sw_trap_req,
  input wire logic [7:0] sw_trap_type,
  input wire logic [3:0] irq_level,
  output logic trap_taken,
  output logic [31:0] trap_vector,
  output logic win_ok,
  input wire logic [4:0] ra_idx,
  input wire logic [4:0] rb_idx,
  input wire logic gpr_wr,
  input wire logic [4:0] gpr_wr_idx,
  input wire logic [31:0] gpr_wr_data,
  output logic [31:0] ra_data,
  output logic [31:0] rb_data,
  output logic supervisor,
  output logic single_vector
);
  import iusr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  iusr_status_t st_r;
  logic [WIM_W-1:0] wim_r;
  logic [19:0] tba_r;
  logic [7:0] tt_r;
  logic svt_r;
  logic [3:0] irq_s1_r;
  logic [3:0] irq_s2_r;
  logic trap_taken_r;

  logic [2:0] cwp_dec;
  logic [2:0] cwp_inc;
  logic irq_take;
  logic save_bad;
  logic rest_bad;
  logic trap_go;
  logic [7:0] trap_code;

  assign cwp_dec = st_r.current_window_pointer - 3'h1;
  assign cwp_inc = st_r.current_window_pointer + 3'h1;

  // level input comes from outside, sync before use
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_s1_r <= 4'h0;
      irq_s2_r <= 4'h0;
    end
    else if (clk_en)
    begin
      irq_s1_r <= irq_level;
      irq_s2_r <= irq_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // trap decision
  // ----------------------------------------------------------------
  // window faults outrank software traps, which outrank interrupts;
  // only one trap is taken per cycle, the others must be raised again
  // level 15 ignores the level mask
  assign irq_take = st_r.et && irq_s2_r != 4'h0
                    && (irq_s2_r == NMI_LEVEL[3:0] || irq_s2_r > st_r.processor_interrupt_level);
  // window change into invalid window traps
  assign save_bad = save_req && wim_r[cwp_dec];
  assign rest_bad = (restore_req || rett_req) && wim_r[cwp_inc];

  always_comb
  begin
    trap_go = 1'b0;
    trap_code = 8'h00;
    if (save_bad)
    begin
      trap_go = 1'b1;
      trap_code = TT_WIN_OVF;
    end
    else if (rest_bad)
    begin
      trap_go = 1'b1;
      trap_code = TT_WIN_UNF;
    end
    else if (sw_trap_req)
    begin
      trap_go = 1'b1;
      trap_code = sw_trap_type;
    end
    else if (irq_take)
    begin
      trap_go = 1'b1;
      trap_code = TT_INTR_BASE | {4'h0, irq_s2_r};
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  // undefined fields are given zero anyway so simulation stays known
  // a trap in the same cycle as a status write wins: the write is lost
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '{icc: 4'h0, processor_interrupt_level: 4'h0, sup: 1'b1, prior: 1'b0, et: 1'b0, current_window_pointer: 3'h0};
    end
    else if (clk_en)
    begin
      if (trap_go)
      begin
        st_r.prior <= st_r.sup;
        st_r.sup <= 1'b1;
        st_r.et <= 1'b0;
        st_r.current_window_pointer <= cwp_dec;
      end
      else if (reg_wr && reg_addr == ADDR_STATUS)
      begin
        st_r.icc <= reg_wdata[ICC_HI:ICC_LO];
        st_r.processor_interrupt_level <= reg_wdata[PIL_HI:PIL_LO];
        st_r.sup <= reg_wdata[SUP_BIT];
        st_r.prior <= reg_wdata[PRIOR_BIT];
        st_r.et <= reg_wdata[ET_BIT];
        st_r.current_window_pointer <= reg_wdata[CWP_HI:CWP_LO];
      end
      else
      begin
        if (icc_wr)
          st_r.icc <= icc_in;
        if (save_req)
          st_r.current_window_pointer <= cwp_dec;
        else if (restore_req)
          st_r.current_window_pointer <= cwp_inc;
        else if (rett_req)
        begin
          st_r.current_window_pointer <= cwp_inc;
          st_r.sup <= st_r.prior;
          st_r.et <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mask, trap base, single vector
  // ----------------------------------------------------------------
  // window invalid mask
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      wim_r <= '0;
    else if (clk_en && reg_wr && reg_addr == ADDR_WIM)
      wim_r <= reg_wdata[WIM_W-1:0];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tba_r <= 20'h00000;
    else if (clk_en && reg_wr && reg_addr == ADDR_TBV)
      tba_r <= reg_wdata[31:TBA_LO];
  end

  // trap type set by hardware only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tt_r <= 8'h00;
    else if (clk_en && trap_go)
      tt_r <= trap_code;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      svt_r <= 1'b0;
    else if (clk_en && reg_wr && reg_addr == ADDR_SVT)
      svt_r <= reg_wdata[0];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      trap_taken_r <= 1'b0;
    else if (clk_en)
      trap_taken_r <= trap_go;
  end

  assign trap_taken = trap_taken_r;
  // vector is built from registers so it is ready in the cycle that
  // trap_taken rises, without an extra pipeline stage
  // low nibble always zero
  // with single vector all traps go to the base
  assign trap_vector = svt_r ? {tba_r, 12'h000} : {tba_r, tt_r, 4'h0};
  assign win_ok = !(save_bad || rest_bad);
  assign supervisor = st_r.sup;
  assign single_vector = svt_r;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // reserved bits read as zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en && reg_rd)
    begin
      unique case (reg_addr)
        ADDR_STATUS: reg_rdata <= {IMPL_VER_ID, st_r.icc, 8'h00, st_r.processor_interrupt_level, st_r.sup,
                                   st_r.prior, st_r.et, 2'h0, st_r.current_window_pointer};
        ADDR_WIM: reg_rdata <= {24'h000000, wim_r};
        ADDR_TBV: reg_rdata <= {tba_r, tt_r, 4'h0};
        ADDR_SVT: reg_rdata <= {31'h0000_0000, svt_r};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // windowed register file
  // ----------------------------------------------------------------
  // 136 physical words
  iusr_gpr_bank u_gpr
  (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .current_window_pointer(st_r.current_window_pointer),
    .ra_idx(ra_idx),
    .rb_idx(rb_idx),
    .wr_en(gpr_wr),
    .wr_idx(gpr_wr_idx),
    .wr_data(gpr_wr_data),
    .ra_data(ra_data),
    .rb_data(rb_data)
  );
endmodule
`default_nettype wire
